// ---- src/bmc_codec_params.svh ----
/*
  Timing constants and widths for the biphase mark line codec.
  Assumes a 100 MHz core clock and a 300 kbit/s nominal line rate.
*/
`ifndef BMC_CODEC_PARAMS_SVH
`define BMC_CODEC_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and bit timing
// ----------------------------------------------------------------------
// Core clock period in picoseconds.
`define BMC_CLK_PERIOD_PS 10000
// Nominal bit period in picoseconds (300 kbit/s).
`define BMC_BIT_PERIOD_PS 3333333
// Half of a bit period in clock cycles, rounded down.
`define BMC_HALF_CYCLES (`BMC_BIT_PERIOD_PS / 2 / `BMC_CLK_PERIOD_PS)
// Width of the interval counters.
`define BMC_CNT_W 12
// Interval limits for classifying received edges, in clock cycles.
`define BMC_SHORT_MIN (`BMC_HALF_CYCLES / 2)
`define BMC_SHORT_MAX ((`BMC_HALF_CYCLES * 3) / 2)
`define BMC_LONG_MAX ((`BMC_HALF_CYCLES * 5) / 2)

`endif

// ---- src/bmc_codec_pkg.sv ----
/*
  Types shared by the biphase mark codec.
  Assumes the timing header is compiled first.
*/
package bmc_codec_pkg;

  // Transmit request from the digital core: one bit and its markers.
  typedef struct packed {
    logic valid;
    logic data;
    logic last;
  } tx_bit_t;

  // Received bit handed back to the digital core.
  typedef struct packed {
    logic valid;
    logic data;
  } rx_bit_t;

  // Transmitter sequence states.
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_LEAD,
    TX_FIRST,
    TX_SECOND,
    TX_CLOSE
  } tx_state_t;

endpackage : bmc_codec_pkg

// ---- src/bmc_rx_decoder.sv ----
/*
  Receive decoder: turns intervals between line edges into bits.
  Assumes a synchronised line level from the same clock domain.
*/
`timescale 1ns/100ps
`include "bmc_codec_params.svh"

module bmc_rx_decoder
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_line,
  output bmc_codec_pkg::rx_bit_t o_bit
);

  // ----------------------------------------------------------------------
  // Edge timing
  // ----------------------------------------------------------------------
  logic line_reg;               // Previous line sample.
  logic [`BMC_CNT_W-1:0] cnt_reg; // Cycles since the last edge.
  logic half_seen_reg;          // First half of a one was seen.
  logic locked_reg;             // A valid interval has been seen.
  bmc_codec_pkg::rx_bit_t bit_reg;

  wire edge_hit = i_line ^ line_reg;
  wire is_short = (cnt_reg >= `BMC_CNT_W'(`BMC_SHORT_MIN)) &&
                  (cnt_reg < `BMC_CNT_W'(`BMC_SHORT_MAX));
  wire is_long = (cnt_reg >= `BMC_CNT_W'(`BMC_SHORT_MAX)) &&
                 (cnt_reg < `BMC_CNT_W'(`BMC_LONG_MAX));
  wire cnt_top = &cnt_reg;

  assign o_bit = bit_reg;

  // Intervals are classified at each edge; any odd interval drops lock,
  // so a missed first edge only costs the opening preamble bit.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst || !i_enable)
    begin
      line_reg <= i_line;
      cnt_reg <= '0;
      half_seen_reg <= 1'b0;
      locked_reg <= 1'b0;
      bit_reg <= '0;
    end
    else
    begin
      line_reg <= i_line;
      bit_reg.valid <= 1'b0;
      if (edge_hit)
      begin
        cnt_reg <= '0;
        // A full-period gap is a zero; two half gaps make a one.
        if (is_long)
        begin
          bit_reg <= '{valid: locked_reg && !half_seen_reg, data: 1'b0};
          locked_reg <= 1'b1;
          half_seen_reg <= 1'b0;
        end
        else if (is_short)
        begin
          bit_reg <= '{valid: half_seen_reg, data: 1'b1};
          half_seen_reg <= !half_seen_reg;
          locked_reg <= 1'b1;
        end
        else
        begin
          // Glitch or over-long gap: restart and resynchronise.
          half_seen_reg <= 1'b0;
          locked_reg <= 1'b0;
        end
      end
      else if (!cnt_top)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      else
      begin
        // Silence ends the frame.
        locked_reg <= 1'b0;
        half_seen_reg <= 1'b0;
      end
    end
  end

endmodule : bmc_rx_decoder

// ---- src/pd_bmc_phy_codec.sv ----
/*
  Biphase mark transmitter and receiver for the configuration line.
  Assumes the core supplies one bit per request and the orientation
  result comes from the attach logic; the line pins are split into
  input, output and output enable for each of the two lines.
*/
// Notes on behaviour
// - Toggle line at the start of every bit.
// - Extra mid-bit toggle for a one bit.
// - Preamble starts by driving the low level.
// - Receiver survives a lost first preamble edge.
// - One closing edge follows the final bit.
// - Drive only while sending, else high impedance.
// - Use only the line chosen by orientation.
// - One talker on the wire at once.
`timescale 1ns/100ps
`include "bmc_codec_params.svh"

module pd_bmc_phy_codec
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_orient_b,
  input wire logic i_rx_enable,
  input wire bmc_codec_pkg::tx_bit_t i_tx_bit,
  output logic o_tx_ready,
  output logic o_tx_busy,
  output bmc_codec_pkg::rx_bit_t o_rx_bit,
  input wire logic i_config_line_a,
  output logic o_config_line_a,
  output logic o_config_line_a_oe,
  input wire logic i_config_line_b,
  output logic o_config_line_b,
  output logic o_config_line_b_oe
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] a_sync_reg; // Bit 0 is read only by bit 1.
  logic [1:0] b_sync_reg;
  logic [1:0] orient_sync_reg;

  // Both lines and the orientation come from outside the clock domain.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      a_sync_reg <= 2'b11;
      b_sync_reg <= 2'b11;
      orient_sync_reg <= 2'b00;
    end
    else
    begin
      a_sync_reg <= {a_sync_reg[0], i_config_line_a};
      b_sync_reg <= {b_sync_reg[0], i_config_line_b};
      orient_sync_reg <= {orient_sync_reg[0], i_orient_b};
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  bmc_codec_pkg::tx_state_t state_reg;
  bmc_codec_pkg::tx_state_t state_next;
  logic [`BMC_CNT_W-1:0] half_cnt_reg; // Cycles left in this half bit.
  logic level_reg;                     // Level being driven.
  logic bit_reg;                       // Bit being sent.
  logic last_reg;                      // Bit being sent is the final one.
  logic orient_reg;                    // Line choice frozen for a frame.
  logic tx_ready_reg;
  logic drive_a_reg;
  logic drive_b_reg;
  // Busy gets a flop of its own so that the output leaves a register
  // and still lines up with the two drive enables.
  logic busy_reg;

  wire half_done = (half_cnt_reg == '0);
  wire take_bit = i_tx_bit.valid && tx_ready_reg;
  wire sending = (state_reg != bmc_codec_pkg::TX_IDLE);

  // The next state is chosen from the current one, the bit timer, the request handshake and the final-bit marker.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      bmc_codec_pkg::TX_IDLE:
        if (take_bit)
          state_next = bmc_codec_pkg::TX_LEAD;
      bmc_codec_pkg::TX_LEAD:
        if (half_done)
          state_next = bmc_codec_pkg::TX_FIRST;
      bmc_codec_pkg::TX_FIRST:
        if (half_done)
          state_next = bmc_codec_pkg::TX_SECOND;
      bmc_codec_pkg::TX_SECOND:
        if (half_done)
        begin
          if (last_reg)
            state_next = bmc_codec_pkg::TX_CLOSE;
          else if (take_bit)
            state_next = bmc_codec_pkg::TX_FIRST;
          else
            state_next = bmc_codec_pkg::TX_CLOSE; // Underrun ends frame.
        end
      bmc_codec_pkg::TX_CLOSE:
        if (half_done)
          state_next = bmc_codec_pkg::TX_IDLE;
    endcase
  end

  // The state register and the half-bit timer.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state_reg <= bmc_codec_pkg::TX_IDLE;
      half_cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (half_done || !sending)
        half_cnt_reg <= `BMC_CNT_W'(`BMC_HALF_CYCLES - 1);
      else
        half_cnt_reg <= half_cnt_reg - 1'b1;
    end
  end

  // Line level: low for the lead-in, then edges at bit boundaries.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      level_reg <= 1'b0;
      bit_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else if (state_reg == bmc_codec_pkg::TX_IDLE)
    begin
      level_reg <= 1'b0; // Preamble opens at low level.
      if (take_bit)
      begin
        bit_reg <= i_tx_bit.data;
        last_reg <= i_tx_bit.last;
      end
    end
    else if (half_done)
    begin
      unique case (state_reg)
        bmc_codec_pkg::TX_LEAD:
          level_reg <= !level_reg; // Boundary edge of bit one.
        bmc_codec_pkg::TX_FIRST:
          if (bit_reg)
            level_reg <= !level_reg; // Mid-bit edge of a one.
        bmc_codec_pkg::TX_SECOND:
        begin
          // Next boundary edge, or the closing edge after the last bit.
          level_reg <= !level_reg;
          if (take_bit)
          begin
            bit_reg <= i_tx_bit.data;
            last_reg <= i_tx_bit.last;
          end
        end
        default:
          level_reg <= level_reg;
      endcase
    end
  end

  // Ready opens only where the next bit can be taken.
  wire ready_next = (state_next == bmc_codec_pkg::TX_IDLE) ||
                    ((state_next == bmc_codec_pkg::TX_SECOND) &&
                     !last_reg && (half_cnt_reg == `BMC_CNT_W'(1)));

  // Drive enables follow the frame; orientation is frozen per frame.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      tx_ready_reg <= 1'b0;
      orient_reg <= 1'b0;
      drive_a_reg <= 1'b0;
      drive_b_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      tx_ready_reg <= ready_next && !take_bit;
      if (!sending)
        orient_reg <= orient_sync_reg[1];
      // Released whenever no frame is active, so only one talker.
      drive_a_reg <= (state_next != bmc_codec_pkg::TX_IDLE) &&
                     !orient_reg;
      drive_b_reg <= (state_next != bmc_codec_pkg::TX_IDLE) &&
                     orient_reg;
      // Same term as the enables without the line choice.
      busy_reg <= (state_next != bmc_codec_pkg::TX_IDLE);
    end
  end

  assign o_tx_ready = tx_ready_reg;
  assign o_tx_busy = busy_reg;
  assign o_config_line_a = level_reg;
  assign o_config_line_b = level_reg;
  assign o_config_line_a_oe = drive_a_reg;
  assign o_config_line_b_oe = drive_b_reg;

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  // Only the selected line is decoded, and never while we talk.
  wire rx_line = orient_reg ? b_sync_reg[1] : a_sync_reg[1];
  wire rx_en = i_rx_enable && !sending;

  bmc_rx_decoder rx_decoder
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_enable(rx_en),
    .i_line(rx_line),
    .o_bit(o_rx_bit)
  );

endmodule : pd_bmc_phy_codec

// ---- verification/pd_bmc_phy_codec_monitor.sv ----
/*
  Port checker for the line codec, bound to every codec instance.
  Assumes one clock, synchronous reset and the same level on both lines.
*/
`timescale 1ns/100ps
module pd_bmc_phy_codec_monitor
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_orient_b,
  input wire logic o_tx_busy,
  input wire bmc_codec_pkg::rx_bit_t o_rx_bit,
  input wire logic o_config_line_a,
  input wire logic o_config_line_a_oe,
  input wire logic o_config_line_b_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // ---------------------------------------------------------------
  // Edge spacing helper
  // ---------------------------------------------------------------
  // Short names for the enables, and any driver at all.
  logic oe_a, oe_b, drv;
  // Cycles since the level last moved; one cycle of slack each way.
  logic [9:0] gap_reg;
  assign oe_a = o_config_line_a_oe;
  assign oe_b = o_config_line_b_oe;
  assign drv = oe_a || oe_b;
  always_ff @(posedge i_clock)
  begin
    if (!drv || $changed(o_config_line_a))
      gap_reg <= 10'h001;
    else if (gap_reg != 10'h3ff)
      gap_reg <= gap_reg + 10'h001;
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_talk; !(oe_a && oe_b); endproperty
  a_talk: assert property (p_talk) else $error("two drivers");
  property p_side_a; oe_a |-> !i_orient_b; endproperty
  a_side_a: assert property (p_side_a) else $error("wrong line");
  property p_side_b; oe_b |-> i_orient_b; endproperty
  a_side_b: assert property (p_side_b) else $error("wrong line");
  property p_lead; $rose(drv) |-> !o_config_line_a [*8]; endproperty
  a_lead: assert property (p_lead) else $error("lead not low");
  property p_busy; o_tx_busy == drv; endproperty
  a_busy: assert property (p_busy) else $error("busy mismatch");
  property p_cell;
    drv && $past(drv) && $changed(o_config_line_a)
      |-> gap_reg inside {[165:167], [331:333]};
  endproperty
  a_cell: assert property (p_cell) else $error("bad edge");
  property p_close; $fell(drv) |-> gap_reg inside {[165:167]}; endproperty
  a_close: assert property (p_close) else $error("bad close");
  property p_quiet; o_rx_bit.valid |-> !drv; endproperty
  a_quiet: assert property (p_quiet) else $error("rx while tx");
  property p_rst; disable iff (1'b0) i_sys_rst |=> !drv; endproperty
  a_rst: assert property (p_rst) else $error("drive in reset");
  c_tx_a: cover property ($rose(oe_a));
  c_tx_b: cover property ($rose(oe_b));
  c_rx: cover property (o_rx_bit.valid);
endmodule : pd_bmc_phy_codec_monitor

bind pd_bmc_phy_codec pd_bmc_phy_codec_monitor u_monitor (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_orient_b(i_orient_b),
  .o_tx_busy(o_tx_busy), .o_rx_bit(o_rx_bit),
  .o_config_line_a(o_config_line_a),
  .o_config_line_a_oe(o_config_line_a_oe),
  .o_config_line_b_oe(o_config_line_b_oe));

// ---- verification/bmc_far_end.sv ----
/*
  Far-end controller model: sends one coded frame of 16 bits on demand.
  Assumes the bench routes it to the selected line with a high bias.
*/
`timescale 1ns/100ps
module bmc_far_end
(
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [15:0] i_bits,
  input wire logic i_lose_first,
  input wire logic [8:0] i_half,
  output logic o_line,
  output logic o_oe
);
  // Level being driven; a lost first edge starts at the bias level.
  logic lvl;
  initial
  begin
    o_oe = 1'b0;
    o_line = 1'b1;
  end
  // Sends bits oldest first, then a closing edge, then lets go.
  always @(posedge i_clock)
  begin
    if (i_go)
    begin
      lvl = i_lose_first;
      o_oe <= 1'b1;
      o_line <= lvl;
      repeat (i_half) @(posedge i_clock);
      for (int i = 0; i < 17; i++)
      begin
        lvl = !lvl;
        o_line <= lvl;
        repeat (i_half) @(posedge i_clock);
        if (i < 16 && i_bits[i])
        begin
          lvl = !lvl;
          o_line <= lvl;
        end
        if (i < 16)
          repeat (i_half) @(posedge i_clock);
      end
      o_oe <= 1'b0;
      o_line <= !lvl;
    end
  end
endmodule : bmc_far_end

// ---- verification/tb_top.sv ----
/*
  Bench for the line codec with a far-end model on the selected line.
  Assumes a released wire returns to its high bias level.
*/
`timescale 1ns/100ps
module tb_top;
  logic i_clock = 1'b0;
  logic rst = 1'b1, orient = 1'b0, rx_en = 1'b0, go = 1'b0, lose = 1'b0;
  logic [15:0] bits = 16'h0000;
  logic [8:0] half = 9'h0A6;
  bmc_codec_pkg::tx_bit_t tx = '0;
  bmc_codec_pkg::rx_bit_t rxb;
  logic rdy, busy, la, lao, lb, lbo, fl, foe, wa, wb, prev;
  logic [15:0] dec, rx_sh;
  int n_mismatch = 0, checks_done = 0, gap, ndec;
  bit half_seen, skip;
  always #5 i_clock = !i_clock;
  // The wire shows whoever drives it, else the bias level.
  assign wa = lao ? la : (foe && !orient) ? fl : 1'b1;
  assign wb = lbo ? lb : (foe && orient) ? fl : 1'b1;
  pd_bmc_phy_codec dut (.i_clock(i_clock), .i_sys_rst(rst),
    .i_orient_b(orient), .i_rx_enable(rx_en), .i_tx_bit(tx),
    .o_tx_ready(rdy), .o_tx_busy(busy), .o_rx_bit(rxb),
    .i_config_line_a(wa), .o_config_line_a(la), .o_config_line_a_oe(lao),
    .i_config_line_b(wb), .o_config_line_b(lb), .o_config_line_b_oe(lbo));
  bmc_far_end far (.i_clock(i_clock), .i_go(go), .i_bits(bits),
    .i_lose_first(lose), .i_half(half), .o_line(fl), .o_oe(foe));
  // Decodes the codec's own output from edge spacing; lead edge skipped.
  always @(posedge i_clock)
  begin
    gap++;
    if (!(lao || lbo))
    begin
      gap = 0;
      half_seen = 0;
      skip = 1;
    end
    else if ((lao ? la : lb) !== prev)
    begin
      if (gap < 250 && !skip)
        half_seen = !half_seen;
      if (!skip && !half_seen)
      begin
        dec[ndec] = (gap < 250);
        ndec++;
      end
      skip = 0;
      gap = 0;
    end
    prev = lao ? la : lb;
  end
  // Received bits shift in from the top, newest last.
  always @(posedge i_clock)
    if (rxb.valid === 1'b1)
      rx_sh <= {rxb.data, rx_sh[15:1]};
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // Sends n bits back to back and decodes them from the wire.
  // With lst low no bit is marked final, so the frame ends by underrun.
  task automatic tx_frame(input logic ob, input logic [15:0] b, input int n,
    input logic lst);
    int k;
    orient <= ob;
    ndec = 0;
    dec = '0;
    repeat (8) @(posedge i_clock);
    for (int i = 0; i < n; i++)
    begin
      tx <= {1'b1, b[i], lst && (i == n - 1)};
      k = 0;
      do @(posedge i_clock); while (rdy !== 1'b1 && ++k < 2000);
      if (k >= 2000) n_mismatch++;
    end
    tx <= '0;
    k = 0;
    do @(posedge i_clock); while (busy !== 1'b0 && ++k < 2000);
    if (k >= 2000) n_mismatch++;
    check("tx bits", dec, b);
    check("tx count", 16'(ndec), 16'(n));
  endtask : tx_frame
  // Far end sends preamble then d; only the tail must come through.
  task automatic rx_frame(input logic ob, lz, input logic [8:0] h,
    input logic [7:0] d);
    int k;
    orient <= ob;
    lose <= lz;
    half <= h;
    bits <= {d, 8'hAA};
    rx_en <= 1'b1;
    repeat (4200) @(posedge i_clock);
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
    k = 0;
    do @(posedge i_clock); while (foe !== 1'b0 && ++k < 9000);
    if (k >= 9000) n_mismatch++;
    repeat (20) @(posedge i_clock);
    check("rx data", rx_sh[15:8], d);
  endtask : rx_frame
  initial
  begin
    repeat (10) @(posedge i_clock);
    rst <= 1'b0;
    repeat (2) @(posedge i_clock);
    check("idle drive", {lao, lbo, busy, rdy}, 4'b0001);
    tx_frame(1'b0, 16'h00B5, 9, 1'b1);
    tx_frame(1'b1, 16'h0001, 1, 1'b1);
    tx_frame(1'b0, 16'h0006, 3, 1'b0);
    rx_frame(1'b0, 1'b0, 9'h0A6, 8'hC5);
    rx_frame(1'b1, 1'b1, 9'h0B4, 8'h3A);
    test_done;
  end
  // A hang counts as a mismatch; the full run needs about 26000 cycles.
  initial
  begin
    repeat (60000) @(posedge i_clock);
    n_mismatch++;
    test_done;
  end
endmodule : tb_top
